// >>> shared/wpot_consts.svh
/*
  constants for the two-wire wiper register slave: direction bit, address, reset value, bit counts.
  assumes nothing beyond being included by bare name.
*/
`ifndef WPOT_CONSTS_SVH
`define WPOT_CONSTS_SVH
`define WPOT_WIPER_RESET 8'h80
`define WPOT_WIPER_ADDR 8'h00
`define WPOT_WIPER_MIN 8'h00
`define WPOT_WIPER_MAX 8'hFF
`define WPOT_DIR_READ 1'b1
`define WPOT_LAST_BIT 3'h7
`define WPOT_BIT_ZERO 3'h0
`define WPOT_PWRUP_CYCLES 16'h0010
`endif

// >>> shared/wpot_pkg.sv
/*
  types for the two-wire wiper register slave.
  assumes the constants header is compiled alongside.
*/
package wpot_pkg;
  typedef enum logic [2:0] {
    WPOT_IDLE,
    WPOT_ID,
    WPOT_ADDR,
    WPOT_WDATA,
    WPOT_RDATA,
    WPOT_RACK
  } wpot_state_e;
endpackage : wpot_pkg

// >>> src/wpot_slave.sv
/*
  two-wire bus slave holding one 8-bit volatile wiper position register that picks the tap
  of a resistor string; the tap select is a one-hot vector from low_terminal to high_terminal.
  assumes an external master drives scl, an open-drain data line with pull-up, and clk_i much
  faster than scl (50 MHz against a bench scl period of 160 ns).
*/
// Functional notes
// - one 8-bit volatile wiper position register alone chooses the tap.
// - value 00h selects the tap nearest the low terminal.
// - value FFh selects the tap nearest the high terminal.
// - each increment moves the tap one step toward the high terminal.
// - the register starts at 80h after power-up.
// - address byte 00h reaches the register; all transfers target it.
// - device is slave only; master starts transfers and drives the clock.
// - bytes travel most significant bit first.
// - data changes only while clock low; high-clock changes mean start or stop.
// - data pin is released after power-up.
// - everything is ignored until a start is seen.
// - a start during power-up is disregarded.
// - stop ends every operation and returns the device to standby.
// - transmitter releases data after eight bits; receiver acknowledges on ninth.
// - device acknowledges valid identifier, address, and write data bytes.
// - identifier is seven fixed bits plus direction bit, 1 read, 0 write.
// - write data shifts in and loads on the falling clock of its last bit.
// - register loads only with valid id, valid address, right pulse count.
// - device keeps sending while master acknowledges each byte; stop ends it.
`timescale 1ns/10ps
`include "wpot_consts.svh"
module wpot_slave #(
  parameter logic [6:0] DEV_ID = 7'h3A, // device identifier, value arbitrary
  parameter int PWRUP_CYCLES = `WPOT_PWRUP_CYCLES // power-up hold-off length
) (
  input wire logic clk_i, // system clock, 50 MHz
  input wire logic rst_b_i, // synchronous reset, active low
  input wire logic scl_i, // serial clock from master
  input wire logic sda_i, // serial data line level
  output logic sda_o, // serial data drive value, always low
  output logic sda_oe_b_o, // low while the device pulls data low
  output logic [7:0] wiper_position_o, // wiper position register
  output logic [255:0] tap_sel_o // one-hot tap, bit 0 nearest low terminal
);
  // synchronised bus lines: first stage, second stage, one more for edge finding
  logic scl_m_q, scl_s_q, scl_p_q;
  logic sda_m_q, sda_s_q, sda_p_q;
  // power-up hold-off
  logic [15:0] pwr_cnt_q;
  logic pwr_ok;
  // line events; a bit fall is a clock fall that belongs to a data or acknowledge bit
  logic scl_rise, scl_fall, start_ev, stop_ev;
  logic pulse_seen_q;
  logic bit_fall;
  // protocol state
  wpot_pkg::wpot_state_e state_q;
  logic [2:0] bit_q;
  logic ack_phase_q;
  logic [7:0] shift_q;
  logic [7:0] tx_q;
  logic addr_ok_q;
  logic drive_q;
  // the wiper register itself
  logic [7:0] wiper_q;
  logic [7:0] rx_byte;

  // identifier compare; the state decision and the acknowledge drive share it
  // so they can never disagree about whether a byte was ours
  function automatic logic id_match(input logic [7:0] byte_v);
    id_match = (byte_v[7:1] == DEV_ID);
  endfunction : id_match

  // address compare; the wiper register is the only location
  function automatic logic addr_match(input logic [7:0] byte_v);
    addr_match = (byte_v == `WPOT_WIPER_ADDR);
  endfunction : addr_match

  // the counted fall that closes the eighth bit of a byte
  function automatic logic last_bit_fall(input logic fall_v, input logic ack_v, input logic [2:0] bit_v);
    last_bit_fall = fall_v && !ack_v && (bit_v == `WPOT_LAST_BIT);
  endfunction : last_bit_fall

  // two-stage synchronisers, then a third stage for edge finding
  // reset to the idle-high bus level so no false edge is seen as reset ends
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      scl_m_q <= 1'b1;
      scl_s_q <= 1'b1;
      scl_p_q <= 1'b1;
      sda_m_q <= 1'b1;
      sda_s_q <= 1'b1;
      sda_p_q <= 1'b1;
    end
    else
    begin
      scl_m_q <= scl_i;
      scl_s_q <= scl_m_q;
      scl_p_q <= scl_s_q;
      sda_m_q <= sda_i;
      sda_s_q <= sda_m_q;
      sda_p_q <= sda_s_q;
    end
  end

  // power-up hold-off counter
  // counts up once after reset, then holds; starts are dropped until it saturates
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
      pwr_cnt_q <= 16'h0000;
    else if (!pwr_ok)
      pwr_cnt_q <= pwr_cnt_q + 16'h0001;
  end
  assign pwr_ok = (pwr_cnt_q >= 16'(PWRUP_CYCLES));

  // line event decode
  // a data change with clock high is only ever start or stop, never data
  assign scl_rise = scl_s_q & ~scl_p_q;
  assign scl_fall = ~scl_s_q & scl_p_q;
  assign start_ev = pwr_ok & scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
  assign stop_ev = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;
  // incoming byte, msb first, completed by the bit sampled now
  assign rx_byte = {shift_q[6:0], sda_s_q};

  // the master's clock fall that closes a start is not a data bit
  // a clock rise must follow each start before falls are counted; otherwise the
  // first byte would close one bit early
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
      pulse_seen_q <= 1'b0;
    else if (start_ev)
      pulse_seen_q <= 1'b0;
    else if (scl_rise)
      pulse_seen_q <= 1'b1;
  end
  assign bit_fall = scl_fall & pulse_seen_q;

  // protocol state machine
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      state_q <= wpot_pkg::WPOT_IDLE;
      bit_q <= `WPOT_BIT_ZERO;
      ack_phase_q <= 1'b0;
      shift_q <= `WPOT_WIPER_MIN;
      addr_ok_q <= 1'b0;
    end
    // stop returns to standby and drops any partial write
    else if (stop_ev)
    begin
      state_q <= wpot_pkg::WPOT_IDLE;
      ack_phase_q <= 1'b0;
      addr_ok_q <= 1'b0;
    end
    // start or repeated start begins an identifier byte
    else if (start_ev)
    begin
      state_q <= wpot_pkg::WPOT_ID;
      bit_q <= `WPOT_BIT_ZERO;
      ack_phase_q <= 1'b0;
    end
    else if (scl_rise && !ack_phase_q && state_q != wpot_pkg::WPOT_IDLE && state_q != wpot_pkg::WPOT_RACK)
    begin
      shift_q <= rx_byte;
    end
    else if (bit_fall && state_q != wpot_pkg::WPOT_IDLE)
    begin
      if (ack_phase_q)
      begin
        // end of ninth clock: move to next byte
        ack_phase_q <= 1'b0;
        bit_q <= `WPOT_BIT_ZERO;
        case (state_q)
          wpot_pkg::WPOT_ID:
            // direction bit picks read or address phase
            state_q <= (shift_q[0] == `WPOT_DIR_READ) ? wpot_pkg::WPOT_RDATA : wpot_pkg::WPOT_ADDR;
          wpot_pkg::WPOT_ADDR:
            state_q <= wpot_pkg::WPOT_WDATA;
          // further bytes of a write are acknowledged and each one loads the register
          wpot_pkg::WPOT_WDATA:
            state_q <= wpot_pkg::WPOT_WDATA;
          default:
            state_q <= wpot_pkg::WPOT_IDLE;
        endcase
      end
      else if (state_q == wpot_pkg::WPOT_RACK)
      begin
        // third sync stage still holds the master's ninth-bit answer: low continues the read
        state_q <= sda_p_q ? wpot_pkg::WPOT_IDLE : wpot_pkg::WPOT_RDATA;
        bit_q <= `WPOT_BIT_ZERO;
      end
      else if (bit_q == `WPOT_LAST_BIT)
      begin
        bit_q <= `WPOT_BIT_ZERO;
        case (state_q)
          // wrong identifier: no acknowledge, idle until next start
          wpot_pkg::WPOT_ID:
            if (id_match(shift_q))
              ack_phase_q <= 1'b1;
            else
              state_q <= wpot_pkg::WPOT_IDLE;
          wpot_pkg::WPOT_ADDR:
          begin
            addr_ok_q <= addr_match(shift_q);
            if (addr_match(shift_q))
              ack_phase_q <= 1'b1;
            else
              state_q <= wpot_pkg::WPOT_IDLE;
          end
          wpot_pkg::WPOT_WDATA:
            ack_phase_q <= 1'b1;
          // after eight bits sent, release and wait for master answer
          default:
            state_q <= wpot_pkg::WPOT_RACK;
        endcase
      end
      else
        bit_q <= bit_q + 3'h1;
    end
  end

  // load on the falling clock after the eighth data bit, only after checks
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
      wiper_q <= `WPOT_WIPER_RESET;
    else if (last_bit_fall(bit_fall, ack_phase_q, bit_q) && !stop_ev && !start_ev
             && state_q == wpot_pkg::WPOT_WDATA && addr_ok_q)
      wiper_q <= shift_q;
  end

  // read shift register: load at start of each read byte, shift on each falling clock
  // msb goes out first
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
      tx_q <= `WPOT_WIPER_MIN;
    else if (scl_fall && ack_phase_q && state_q == wpot_pkg::WPOT_ID)
      tx_q <= wiper_q;
    else if (scl_fall && state_q == wpot_pkg::WPOT_RACK)
      tx_q <= wiper_q;
    else if (scl_fall && state_q == wpot_pkg::WPOT_RDATA && !ack_phase_q)
      tx_q <= {tx_q[6:0], 1'b0};
  end

  // data line drive, changed just after a falling clock, or cleared by a start or stop
  // released from reset; ack pulls low; only ever a slave drive
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
      drive_q <= 1'b0;
    else if (stop_ev || start_ev)
      drive_q <= 1'b0;
    // counted falls only, so the drive settles well before the master's next rise samples it
    else if (bit_fall)
    begin
      if (last_bit_fall(bit_fall, ack_phase_q, bit_q) && state_q == wpot_pkg::WPOT_ID)
        drive_q <= id_match(shift_q);
      else if (last_bit_fall(bit_fall, ack_phase_q, bit_q) && state_q == wpot_pkg::WPOT_ADDR)
        drive_q <= addr_match(shift_q);
      // every write data byte is acknowledged
      else if (last_bit_fall(bit_fall, ack_phase_q, bit_q) && state_q == wpot_pkg::WPOT_WDATA)
        drive_q <= 1'b1;
      // released in the ninth cycle of a read byte
      else if (last_bit_fall(bit_fall, ack_phase_q, bit_q) && state_q == wpot_pkg::WPOT_RDATA)
        drive_q <= 1'b0;
      // msb of the first read byte, right after the identifier acknowledge
      else if (ack_phase_q && state_q == wpot_pkg::WPOT_ID && shift_q[0] == `WPOT_DIR_READ)
        drive_q <= ~wiper_q[7];
      // master acked: first bit of the next byte
      else if (state_q == wpot_pkg::WPOT_RACK)
        drive_q <= ~sda_p_q & ~wiper_q[7];
      // remaining read bits; tx_q shifts at this same edge, so bit 6 is the next one out
      else if (state_q == wpot_pkg::WPOT_RDATA && !ack_phase_q)
        drive_q <= ~tx_q[6];
      else
        drive_q <= 1'b0;
    end
  end

  assign sda_o = 1'b0;
  assign sda_oe_b_o = ~drive_q;
  assign wiper_position_o = wiper_q;

  // tap decode: 00h lowest tap, FFh highest, one step per count
  // a one-hot select cannot skip or double a tap, so monotonic motion follows from the index
  always_comb
  begin
    tap_sel_o = 256'h0;
    tap_sel_o[wiper_q] = 1'b1;
  end
endmodule : wpot_slave

// >>> tb/tb_top.sv
/* bench for the wiper slave: table of writes with read-back, then refusals.
   assumes the master model and checker are compiled first. */
`timescale 1ns/10ps
`define CMP(g, e) begin comparisons++; if ((g) !== (e)) begin error_cnt++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top;
  logic clk_i;
  logic rst_b_i;
  logic scl;
  logic m_oe_b;
  logic sda_o;
  logic sda_oe_b_o;
  logic [7:0] wiper_position_o;
  logic [255:0] tap_sel_o;
  logic [2:0] acks;
  logic [15:0] q;
  logic r;
  int error_cnt = 0;
  int comparisons = 0;
  int cycles = 0;
  // each row: written byte, expected register
  logic [15:0] rows [6] = '{16'h0000, 16'hFFFF, 16'h0101, 16'hFEFE, 16'hA5A5, 16'h5C5C};
  // wired-and with pull-up: released parties read as 1
  wire logic sda = m_oe_b & (sda_oe_b_o | sda_o);
  wpot_slave wpot_slave_inst (.clk_i(clk_i), .rst_b_i(rst_b_i), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
    .sda_oe_b_o(sda_oe_b_o), .wiper_position_o(wiper_position_o), .tap_sel_o(tap_sel_o));
  wpot_master wpot_master_inst (.sda_i(sda), .scl_o(scl), .sda_oe_b_o(m_oe_b));
  // 50 MHz clock
  initial
  begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_sim
  // hang guard; the run needs about 4630 clocks
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      error_cnt++;
      end_sim();
    end
  end
  initial
  begin
    rst_b_i = 1'b0;
    repeat (5) @(negedge clk_i);
    `CMP(wiper_position_o, 8'h80)
    `CMP(tap_sel_o[128], 1'b1)
    `CMP(sda_oe_b_o, 1'b1)
    rst_b_i = 1'b1;
    wpot_master_inst.wr(8'h74, 8'h00, 8'h11, acks);
    `CMP(acks, 3'b111)
    `CMP(wiper_position_o, 8'h80)
    $display("test reset done");
    foreach (rows[i])
    begin
      wpot_master_inst.wr(8'h74, 8'h00, rows[i][15:8], acks);
      `CMP(acks, 3'b000)
      `CMP(wiper_position_o, rows[i][7:0])
      `CMP(tap_sel_o, 256'h1 << rows[i][7:0])
      wpot_master_inst.rd(7'h3A, acks, q);
      `CMP(acks, 3'b000)
      `CMP(q, {2{rows[i][7:0]}})
      $display("test row %0d done", i);
    end
    wpot_master_inst.wr(8'h76, 8'h00, 8'h33, acks);
    `CMP(acks, 3'b111)
    wpot_master_inst.wr(8'h74, 8'h01, 8'h33, acks);
    `CMP(acks, 3'b011)
    `CMP(wiper_position_o, 8'h5C)
    $display("test refusals done");
    wpot_master_inst.start();
    wpot_master_inst.xfer(8'h74, 1'b1, q[7:0], r);
    wpot_master_inst.xfer(8'h00, 1'b1, q[7:0], r);
    repeat (5) wpot_master_inst.bit_io(1'b0, r);
    wpot_master_inst.stop();
    `CMP(wiper_position_o, 8'h5C)
    $display("test cut write done");
    end_sim();
  end
endmodule : tb_top
bind wpot_slave wpot_slave_properties wpot_slave_properties_inst (.clk_i(clk_i), .rst_b_i(rst_b_i),
  .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_b_o(sda_oe_b_o),
  .wiper_position_o(wiper_position_o), .tap_sel_o(tap_sel_o));

// >>> tb/wpot_master.sv
/* two-wire master model that drives scl and an open-drain data line.
   assumes a pull-up on data and that tasks start on a falling clk edge. */
`timescale 1ns/10ps
module wpot_master (
  input wire logic sda_i, // resolved data line
  output logic scl_o, // serial clock, idle high
  output logic sda_oe_b_o // low while pulling data
);
  initial
  begin
    scl_o = 1'b1;
    sda_oe_b_o = 1'b1;
  end
  task automatic bit_io(input logic b, output logic r);
    #20 sda_oe_b_o = b;
    #60 scl_o = 1'b1;
    #40 r = sda_i;
    #40 scl_o = 1'b0;
  endtask : bit_io
  task automatic start();
    #20 sda_oe_b_o = 1'b1;
    #60 scl_o = 1'b1;
    #40 sda_oe_b_o = 1'b0;
    #40 scl_o = 1'b0;
  endtask : start
  task automatic stop();
    #20 sda_oe_b_o = 1'b0;
    #60 scl_o = 1'b1;
    #40 sda_oe_b_o = 1'b1;
    #80;
  endtask : stop
  task automatic xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] q, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(d[i], r);
      q[i] = r;
    end
    bit_io(ack_in, ack);
  endtask : xfer
  task automatic wr(input logic [7:0] id, input logic [7:0] a, input logic [7:0] d, output logic [2:0] acks);
    logic [7:0] q;
    start();
    xfer(id, 1'b1, q, acks[2]);
    xfer(a, 1'b1, q, acks[1]);
    xfer(d, 1'b1, q, acks[0]);
    stop();
  endtask : wr
  // read with repeated start, ack then nack
  task automatic rd(input logic [6:0] dev, output logic [2:0] acks, output logic [15:0] q);
    logic [7:0] j;
    logic x;
    start();
    xfer({dev, 1'b0}, 1'b1, j, acks[2]);
    xfer(8'h00, 1'b1, j, acks[1]);
    start();
    xfer({dev, 1'b1}, 1'b1, j, acks[0]);
    xfer(8'hFF, 1'b0, q[15:8], x);
    xfer(8'hFF, 1'b1, q[7:0], x);
    stop();
  endtask : rd
endmodule : wpot_master

// >>> tb/wpot_slave_properties.sv
/* port checker for the wiper slave.
   assumes a bind from the bench and scl low and high of at least 4 clk. */
`timescale 1ns/10ps
module wpot_slave_properties (
  input wire logic clk_i, // system clock
  input wire logic rst_b_i, // sync reset, active low
  input wire logic scl_i, // serial clock
  input wire logic sda_i, // data line level
  input wire logic sda_o, // drive value
  input wire logic sda_oe_b_o, // low while pulling
  input wire logic [7:0] wiper_position_o, // register
  input wire logic [255:0] tap_sel_o // one-hot tap
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  tap_onehot_a:
    assert property (tap_sel_o == (256'h1 << wiper_position_o)) else $error("tap select wrong");
  reset_value_a:
    assert property (disable iff (1'b0) !rst_b_i |=> wiper_position_o == 8'h80 && sda_oe_b_o)
    else $error("reset state wrong");
  // quiet power-up: a start is only taken after the 16-cycle hold-off, and eight bits
  // of at least 8 clk each follow it, so no drive can be legal in the first 80 cycles
  localparam int QUIET_CYCLES = 80;
  logic [6:0] since_rst_q;
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
      since_rst_q <= 7'h00;
    else if (since_rst_q != 7'(QUIET_CYCLES))
      since_rst_q <= since_rst_q + 7'h01;
  end
  pwrup_quiet_a:
    assert property (since_rst_q != 7'(QUIET_CYCLES) |-> sda_oe_b_o) else $error("drive during power-up");
  wiper_on_fall_a:
    assert property ($past(rst_b_i) && !$stable(wiper_position_o) |-> !scl_i && !$past(scl_i, 2) && $past(scl_i, 4))
    else $error("wiper changed off a falling clock");
  drive_steady_a:
    assert property (scl_i && $past(scl_i) |-> $stable(sda_oe_b_o)) else $error("drive moved with clock high");
  stop_idle_a:
    assert property (scl_i && $past(scl_i) && $rose(sda_i) |=> sda_oe_b_o [*8]) else $error("drive after stop");
  ack_hold_a:
    assert property ($fell(sda_oe_b_o) |=> !sda_oe_b_o [*6]) else $error("drive too short");
  ack_timing_a:
    assert property ($fell(sda_oe_b_o) |-> !$past(scl_i, 2) && $past(scl_i, 4) && !sda_o)
    else $error("drive began badly");
endmodule : wpot_slave_properties
